// [shared/lsis_defines.vh]
/*
 * constants for the laser status / interlock sequencer: apb register
 * offsets, field positions, reset values and timing counts.
 * assumes a 100 mhz system clock.
 */
`ifndef LSIS_DEFINES_VH
`define LSIS_DEFINES_VH

// clock rate and derived timing
`define LSIS_CLK_HZ          100000000
`define LSIS_HOLDOFF_S       5
`define LSIS_HOLDOFF_CYC     (`LSIS_HOLDOFF_S * `LSIS_CLK_HZ)
`define LSIS_CLAMP_NS        12000
`define LSIS_CLK_NS          10
`define LSIS_CLAMP_CYC       (`LSIS_CLAMP_NS / `LSIS_CLK_NS)
`define LSIS_BLINK_MS        250
`define LSIS_BLINK_CYC       (`LSIS_BLINK_MS * (`LSIS_CLK_HZ / 1000))
`define LSIS_MINPULSE_CYC    2

// apb register byte offsets
`define LSIS_REG_CTRL        12'h000
`define LSIS_REG_STATUS      12'h004
`define LSIS_REG_HOLDCNT     12'h008

// control register fields
`define LSIS_CTRL_OEM        0
`define LSIS_CTRL_TICKLE_EN  1
`define LSIS_CTRL_RST        32'h0000_0003

// status register fields
`define LSIS_ST_LOOP_OPEN    0
`define LSIS_ST_OVERTEMP     1
`define LSIS_ST_READY        2
`define LSIS_ST_GATE_OPEN    3
`define LSIS_ST_ACTIVE       4
`define LSIS_ST_PERMIT       5
`define LSIS_ST_REFL         6
`define LSIS_ST_HOLD_DONE    7
`define LSIS_ST_RF_EN        8
`define LSIS_ST_TICKLE       9
`define LSIS_ST_LOOP_LATCH   10

`endif

// [hw/lsis_sync.v]
/*
 * three-stage input synchroniser with agreement filter.
 * assumes the input is asynchronous to clk_sys; output changes once
 * the second and third stages agree.
 */
`timescale 1ns/100ps
module lsis_sync #(
	parameter W = 1
) (
	input  wire         clk_sys,
	input  wire         nrst,
	input  wire [W-1:0] din,
	output reg  [W-1:0] dout
);

reg [W-1:0] stg1;
reg [W-1:0] stg2;
reg [W-1:0] stg3;
integer     i;

// only stg2 reads stg1
always @(posedge clk_sys) begin
	if (!nrst) begin
		stg1 <= {W{1'b0}};
		stg2 <= {W{1'b0}};
		stg3 <= {W{1'b0}};
		dout <= {W{1'b0}};
	end else begin
		stg1 <= din;
		stg2 <= stg1;
		stg3 <= stg2;
		for (i = 0; i < W; i = i + 1) begin
			if (stg2[i] == stg3[i])
				dout[i] <= stg3[i];
		end
	end
end

endmodule

// [hw/lsis_apb.v]
/*
 * apb slave for the sequencer: one control register, read-only status
 * and hold-off counter. assumes apb3 master on clk_sys; zero wait states.
 */
`timescale 1ns/100ps
`include "lsis_defines.vh"
module lsis_apb (
	input  wire        clk_sys,
	input  wire        nrst,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output reg  [31:0] prdata,
	output wire        pslverr,
	input  wire [31:0] status,
	input  wire [31:0] holdcnt,
	output reg  [31:0] ctrl
);

wire acc = psel & penable;
wire hit = (paddr == `LSIS_REG_CTRL) | (paddr == `LSIS_REG_STATUS) |
	(paddr == `LSIS_REG_HOLDCNT);

assign pready  = 1'b1;
// unmapped addresses answer with an error and read zero
assign pslverr = acc & ~hit;

always @(posedge clk_sys) begin
	if (!nrst) begin
		ctrl <= `LSIS_CTRL_RST;
	end else if (acc && pwrite && paddr == `LSIS_REG_CTRL) begin
		ctrl <= {30'h0000_0000, pwdata[1:0]};
	end
end

// read data is captured in the setup cycle, so it comes from a flop
// yet still stands through the whole zero-wait access phase
always @(posedge clk_sys) begin
	if (!nrst) begin
		prdata <= 32'h0000_0000;
	end else if (psel && !penable) begin
		case (paddr)
		`LSIS_REG_CTRL:    prdata <= ctrl;
		`LSIS_REG_STATUS:  prdata <= status;
		`LSIS_REG_HOLDCNT: prdata <= holdcnt;
		default:           prdata <= 32'h0000_0000;
		endcase
	end
end

endmodule

// [hw/lsis_top.v]
/*
 * laser status / interlock sequencer: watches the safety loop, thermal
 * trip, beam-gate request, reflected-power fault and pulse command;
 * drives lamps, matching switch-closure outputs, rf enable and the
 * gated pulse drive. assumes all pin inputs are asynchronous to clk_sys
 * and that nrst is asserted at power-up (it is the power cycle).
 */
//
// Behaviour
// - each status output closes exactly while its named condition is true
// - every lamp state except the gate lamp's reflected-fault flash is mirrored on a matching output signal
// - open loop: red interlock lamp, loop output closed, permit open, no tickle
// - missing plug or inputs read as open loop, same outputs
// - thermal trip: red temp lamp, trip output closed, no permit or emission
// - ready and permit only while interlock and temperature both good
// - five-second hold-off after ready before any emission
// - rf power only while ready and gate both asserted
// - ready and gate indications are independent
// - gate closed with ready: permit closed, active open, lamp off
// - qualifying pulses light the emission lamp and close active; tickle not
// - normal: tickle on, ready on, active only during qualifying pulses
// - reflected fault: gate lamp flashes, pulses clamped to 12 us
// - reflected fault keeps other outputs normal, active still follows pulses
// - oem variant: loop fault unlatched, ready returns then hold-off
// - thermal trip latches until power cycle with temperature in range
// - reflected fault clearing restores unclamped pulses without power cycle
//
`timescale 1ns/100ps
`include "lsis_defines.vh"
module lsis_top #(
	parameter HOLDOFF_CYC = `LSIS_HOLDOFF_CYC,
	parameter BLINK_CYC   = `LSIS_BLINK_CYC,
	parameter CLAMP_CYC   = `LSIS_CLAMP_CYC,
	parameter MINPULSE    = `LSIS_MINPULSE_CYC
) (
	input  wire        clk_sys,
	input  wire        nrst,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output wire [31:0] prdata,
	output wire        pslverr,
	input  wire        loop_ok,
	input  wire        loop_present,
	input  wire        temp_trip,
	input  wire        gate_req,
	input  wire        gate_present,
	input  wire        refl_fault,
	input  wire        pulse_cmd,
	input  wire        reset_req,
	output reg         lamp_loop_red,
	output reg         lamp_temp_red,
	output reg         lamp_ready,
	output reg         lamp_gate,
	output reg         lamp_emit,
	output reg         out_loop_open,
	output reg         out_overtemp,
	output reg         out_ready,
	output reg         out_gate_open,
	output reg         out_active,
	output reg         out_permit,
	output reg         rf_enable,
	output reg         tickle_en,
	output reg         pulse_drive
);

////////////////////////////////////////////////////////////////////////
// counter helpers

// counters stick at all ones instead of wrapping into a short count
function [31:0] lsis_inc;
	input [31:0] cnt;
	begin
		if (cnt == 32'hFFFF_FFFF)
			lsis_inc = cnt;
		else
			lsis_inc = cnt + 32'h0000_0001;
	end
endfunction

// true on the final cycle of a count running from 0 to lim-1
function lsis_last;
	input [31:0] cnt;
	input [31:0] lim;
	begin
		lsis_last = (cnt == lim - 32'h0000_0001);
	end
endfunction

////////////////////////////////////////////////////////////////////////
// input synchronisers

wire [7:0] pin_raw = {reset_req, pulse_cmd, refl_fault, gate_present,
	gate_req, temp_trip, loop_present, loop_ok};
wire [7:0] pin_s;

lsis_sync #(
	.W (8)
) u_sync (
	.clk_sys (clk_sys),
	.nrst    (nrst),
	.din     (pin_raw),
	.dout    (pin_s)
);

wire s_loop_ok  = pin_s[0];
wire s_loop_pr  = pin_s[1];
wire s_temp     = pin_s[2];
wire s_gate_req = pin_s[3];
wire s_gate_pr  = pin_s[4];
wire s_refl     = pin_s[5];
wire s_pulse    = pin_s[6];
wire s_rst_req  = pin_s[7];

////////////////////////////////////////////////////////////////////////
// registers

wire [31:0] ctrl;
reg  [31:0] status;
wire [31:0] holdcnt;
wire        oem_mode  = ctrl[`LSIS_CTRL_OEM];
wire        tickle_on = ctrl[`LSIS_CTRL_TICKLE_EN];

lsis_apb u_apb (
	.clk_sys (clk_sys),
	.nrst    (nrst),
	.psel    (psel),
	.penable (penable),
	.pwrite  (pwrite),
	.paddr   (paddr),
	.pwdata  (pwdata),
	.pready  (pready),
	.prdata  (prdata),
	.pslverr (pslverr),
	.status  (status),
	.holdcnt (holdcnt),
	.ctrl    (ctrl)
);

////////////////////////////////////////////////////////////////////////
// fault latches

// absent plug or inputs look exactly like an open loop
wire loop_bad = ~s_loop_ok | ~s_loop_pr;

reg loop_latch;
reg temp_latch;

// a loop fault latches on the keyed build until a reset request with
// the loop good; the oem build follows the input directly
always @(posedge clk_sys) begin
	if (!nrst) begin
		loop_latch <= 1'b0;
	end else if (loop_bad && !oem_mode) begin
		loop_latch <= 1'b1;
	end else if (oem_mode || s_rst_req) begin
		loop_latch <= 1'b0;
	end
end

// set wins; only nrst (power cycle) clears, and it re-latches on the fifth edge
// after release if the trip input is still high, once the synchroniser passes it
always @(posedge clk_sys) begin
	if (!nrst) begin
		temp_latch <= 1'b0;
	end else if (s_temp) begin
		temp_latch <= 1'b1;
	end
end

wire loop_fault = loop_bad | loop_latch;
wire temp_fault = temp_latch | s_temp;
wire ready_cond = ~loop_fault & ~temp_fault;
wire gate_cond  = s_gate_req & s_gate_pr;

////////////////////////////////////////////////////////////////////////
// hold-off counter

reg [31:0] hold_cnt;
reg        hold_done;

always @(posedge clk_sys) begin
	if (!nrst) begin
		hold_cnt  <= 32'h0000_0000;
		hold_done <= 1'b0;
	end else if (!ready_cond) begin
		hold_cnt  <= 32'h0000_0000;
		hold_done <= 1'b0;
	end else if (!hold_done) begin
		if (lsis_last(hold_cnt, HOLDOFF_CYC))
			hold_done <= 1'b1;
		else
			hold_cnt <= lsis_inc(hold_cnt);
	end
end

assign holdcnt = hold_cnt;

wire emit_ok = ready_cond & gate_cond & hold_done;

////////////////////////////////////////////////////////////////////////
// pulse qualification and clamp

reg [31:0] pulse_len;
reg        pulse_q;

// tickle-length pulses are too short to light the emission lamp
always @(posedge clk_sys) begin
	if (!nrst) begin
		pulse_len <= 32'h0000_0000;
		pulse_q   <= 1'b0;
	end else if (!s_pulse) begin
		pulse_len <= 32'h0000_0000;
		pulse_q   <= 1'b0;
	end else begin
		pulse_len <= lsis_inc(pulse_len);
		if (pulse_len >= MINPULSE - 1)
			pulse_q <= 1'b1;
	end
end

// clamp applies only while the fault stands, so clearing it restores
// full pulses at once
wire clamp_cut = s_refl && (pulse_len >= CLAMP_CYC);

wire next_drive  = emit_ok & s_pulse & ~clamp_cut;
wire next_active = emit_ok & pulse_q & ~clamp_cut;

////////////////////////////////////////////////////////////////////////
// blink generator

reg [31:0] blink_cnt;
reg        blink;

always @(posedge clk_sys) begin
	if (!nrst) begin
		blink_cnt <= 32'h0000_0000;
		blink     <= 1'b0;
	end else if (lsis_last(blink_cnt, BLINK_CYC)) begin
		blink_cnt <= 32'h0000_0000;
		blink     <= ~blink;
	end else begin
		blink_cnt <= lsis_inc(blink_cnt);
	end
end

////////////////////////////////////////////////////////////////////////
// outputs, all registered; lamps and switch outputs share one source, except that the gate lamp also takes blink

always @(posedge clk_sys) begin
	if (!nrst) begin
		lamp_loop_red <= 1'b0;
		lamp_temp_red <= 1'b0;
		lamp_ready    <= 1'b0;
		lamp_gate     <= 1'b0;
		lamp_emit     <= 1'b0;
		out_loop_open <= 1'b0;
		out_overtemp  <= 1'b0;
		out_ready     <= 1'b0;
		out_gate_open <= 1'b0;
		out_active    <= 1'b0;
		out_permit    <= 1'b0;
		rf_enable     <= 1'b0;
		tickle_en     <= 1'b0;
		pulse_drive   <= 1'b0;
	end else begin
		lamp_loop_red <= loop_fault;
		out_loop_open <= loop_fault;
		lamp_temp_red <= temp_fault;
		out_overtemp  <= temp_fault;
		lamp_ready    <= ready_cond;
		out_ready     <= ready_cond;
		out_permit    <= ready_cond;
		// flashing gate lamp marks the reflected fault
		lamp_gate     <= gate_cond & (~s_refl | blink);
		out_gate_open <= gate_cond;
		rf_enable     <= ready_cond & gate_cond;
		tickle_en     <= ready_cond & tickle_on;
		lamp_emit     <= next_active;
		out_active    <= next_active;
		pulse_drive   <= next_drive;
	end
end

// status word laid out by the field positions of the defines header
always @* begin
	status                      = 32'h0000_0000;
	status[`LSIS_ST_LOOP_OPEN]  = out_loop_open;
	status[`LSIS_ST_OVERTEMP]   = out_overtemp;
	status[`LSIS_ST_READY]      = out_ready;
	status[`LSIS_ST_GATE_OPEN]  = out_gate_open;
	status[`LSIS_ST_ACTIVE]     = out_active;
	status[`LSIS_ST_PERMIT]     = out_permit;
	status[`LSIS_ST_REFL]       = s_refl;
	status[`LSIS_ST_HOLD_DONE]  = hold_done;
	status[`LSIS_ST_RF_EN]      = rf_enable;
	status[`LSIS_ST_TICKLE]     = tickle_en;
	status[`LSIS_ST_LOOP_LATCH] = loop_latch;
end

endmodule

// [testbench/lsis_top_asserts.sv]
/* checker on the sequencer's pin outputs.
   assumes a bind into lsis_top with shortened hold-off and clamp. */
`timescale 1ns/100ps
module lsis_chk #(
	parameter HOLDOFF_CYC = 50,
	parameter CLAMP_CYC   = 10
) (
	input wire clk_sys,
	input wire nrst,
	input wire refl_fault,
	input wire lamp_loop_red,
	input wire lamp_temp_red,
	input wire lamp_ready,
	input wire lamp_emit,
	input wire out_loop_open,
	input wire out_overtemp,
	input wire out_ready,
	input wire out_gate_open,
	input wire out_active,
	input wire out_permit,
	input wire rf_enable,
	input wire tickle_en,
	input wire pulse_drive
);
	reg [31:0] rdy_cnt;
	reg [31:0] drv_cnt;
	reg [31:0] refl_cnt;
	// refl_fault is a raw pin: wait out the synchroniser before judging
	always @(posedge clk_sys) begin
		if (!nrst) begin
			rdy_cnt  <= 32'h0;
			drv_cnt  <= 32'h0;
			refl_cnt <= 32'h0;
		end else begin
			rdy_cnt  <= out_ready ? rdy_cnt + 32'h1 : 32'h0;
			drv_cnt  <= pulse_drive ? drv_cnt + 32'h1 : 32'h0;
			refl_cnt <= refl_fault ? refl_cnt + 32'h1 : 32'h0;
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	a_lamp_mirror: assert property (
		lamp_loop_red == out_loop_open && lamp_temp_red == out_overtemp
		&& lamp_ready == out_ready && lamp_emit == out_active)
		else $error("lamp and output differ");
	a_permit_ready: assert property (out_permit == out_ready)
		else $error("permit differs from ready");
	a_loop_blocks: assert property (out_loop_open |->
		!out_ready && !tickle_en && !out_active)
		else $error("open loop left emission path on");
	a_temp_blocks: assert property (out_overtemp |->
		!out_ready && !tickle_en && !out_active)
		else $error("thermal trip left emission path on");
	a_temp_latch: assert property (out_overtemp |=> out_overtemp)
		else $error("thermal trip released without reset");
	a_rf_gate: assert property (rf_enable |-> out_ready && out_gate_open)
		else $error("rf enabled without ready and gate");
	a_hold_off: assert property (
		pulse_drive |-> rdy_cnt >= HOLDOFF_CYC - 1)
		else $error("pulse driven inside hold-off");
	a_refl_clamp: assert property (
		refl_cnt > 8 |-> drv_cnt <= CLAMP_CYC)
		else $error("pulse longer than clamp under fault");
	a_active_gate: assert property (
		out_active |-> out_ready && out_gate_open)
		else $error("active with gate shut or not ready");
	c_active: cover property (out_active && refl_cnt > 8);
	c_rf: cover property (rf_enable);
	c_ready_drop: cover property ($fell(out_ready));
endmodule

// [testbench/lsis_ctl_model.sv]
/* machine controller model: drives the sequencer's pin inputs as
   levels. assumes the bench orders each change through set_pins. */
`timescale 1ns/100ps
module lsis_ctl_model (
	input  wire clk_sys,
	output reg  loop_ok,
	output reg  loop_present,
	output reg  temp_trip,
	output reg  gate_req,
	output reg  gate_present,
	output reg  refl_fault,
	output reg  pulse_cmd,
	output reg  reset_req
);
	initial begin
		{loop_ok, loop_present, temp_trip, gate_req, gate_present,
			refl_fault, pulse_cmd, reset_req} = 8'h00;
	end
	// change only after an edge, like the real controller's outputs
	task set_pins(input [7:0] v);
		@(posedge clk_sys);
		{loop_ok, loop_present, temp_trip, gate_req, gate_present,
			refl_fault, pulse_cmd, reset_req} <= v;
	endtask
endmodule

// [testbench/test_lsis_top.sv]
/* bench for the sequencer: controller model on the pins, apb master
   on the registers. assumes shortened hold-off, blink and clamp. */
`timescale 1ns/100ps
module test_lsis_top;
	localparam H = 50;
	localparam C = 10;
	reg         clk_sys, nrst, psel, penable, pwrite, lg;
	reg  [11:0] paddr;
	reg  [31:0] pwdata, rd;
	wire        pready, pslverr, loop_ok, loop_present, temp_trip;
	wire [31:0] prdata;
	wire        gate_req, gate_present, refl_fault, pulse_cmd, reset_req;
	wire        lamp_loop_red, lamp_temp_red, lamp_ready, lamp_gate;
	wire        lamp_emit, out_loop_open, out_overtemp, out_ready;
	wire        out_gate_open, out_active, out_permit, rf_enable;
	wire        tickle_en, pulse_drive;
	integer     err_total, checks, cyc, seed, i, n, run, mx, tog, sl, len_r;
	integer     m_loop, m_temp, m_rdy, m_gate, m_tick, m_lat, m_oem;
	lsis_top #(.HOLDOFF_CYC(H), .BLINK_CYC(4), .CLAMP_CYC(C), .MINPULSE(2))
		dut (.*);
	lsis_ctl_model ctl (.*);
	task chk(input [31:0] got, input [31:0] exp, input [63:0] nm);
		checks = checks + 1;
		if (got !== exp) begin
			err_total = err_total + 1;
			$display("CHECK FAILED %0s exp %0h got %0h", nm, exp, got);
		end
	endtask
	task test_done;
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task apb(input w, input [11:0] a, input [31:0] d);
		@(posedge clk_sys);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'h1;
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'h1);
		rd = prdata;
		sl = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	// pin model: open loop and thermal trip both kill ready
	task put(input [7:0] v);
		ctl.set_pins(v);
		m_loop = !(v[7] && v[6]);
		// keyed build: loop fault holds until a reset request, loop good
		m_lat = !m_oem && (m_loop || (m_lat && !v[0]));
		m_loop = m_loop || m_lat;
		m_temp = m_temp | v[5];
		m_rdy = !m_loop && !m_temp;
		m_gate = v[4] && v[3];
		repeat (8) @(posedge clk_sys);
		chk(out_loop_open, m_loop, "loop");
		chk(out_overtemp, m_temp, "temp");
		chk(out_permit, m_rdy, "permit");
		chk(out_gate_open, m_gate, "gate");
		chk(rf_enable, m_rdy && m_gate, "rf");
		chk(tickle_en, m_rdy && m_tick, "tickle");
		chk(out_ready, m_rdy, "ready");
		chk(lamp_loop_red, m_loop, "lloop");
		chk(lamp_temp_red, m_temp, "ltemp");
		chk(lamp_ready, m_rdy, "lready");
		if (!v[2])
			chk(lamp_gate, m_gate, "lgate");
	endtask
	task smp;
		@(posedge clk_sys);
		run = pulse_drive ? run + 1 : 0;
		mx = run > mx ? run : mx;
		n = out_active ? 1 : n;
		tog = tog + (lamp_gate !== lg);
		lg = lamp_gate;
	endtask
	task fire(input [7:0] v, input integer len);
		run = 0;
		mx = 0;
		tog = 0;
		n = 0;
		ctl.set_pins(v | 8'h02);
		repeat (len) smp;
		// release and sample on one edge so no pulse cycle goes unseen
		fork
			ctl.set_pins(v);
			smp;
		join
		repeat (7) smp;
	endtask
	initial begin
		clk_sys = 1'h0;
		forever #5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total = err_total + 1;
			test_done;
		end
	end
	initial begin
		{nrst, psel, penable, pwrite, paddr, pwdata} = 48'h0;
		{err_total, checks, cyc, m_temp, m_lat, lg} = 0;
		seed = 32'h5C9A4742;
		m_tick = 1;
		m_oem = 1;
		repeat (5) @(posedge clk_sys);
		nrst <= 1'h1;
		put(8'hD8);
		fire(8'hD8, 20);
		chk(n, 0, "holdoff");
		chk(mx, 0, "holddrv");
		repeat (H) @(posedge clk_sys);
		for (i = 0; i < 3; i = i + 1) begin
			len_r = 4 + ($random(seed) & 15);
			fire(8'hD8, len_r);
			chk(n, 1, "emit");
			chk(mx, len_r + 1, "width");
		end
		fire(8'hD8, 0);
		chk(n, 0, "short");
		put(8'hC8);
		fire(8'hC8, 20);
		chk(n, 0, "shut");
		put(8'hD0);
		put(8'h58);
		fire(8'h58, 20);
		chk(n, 0, "loopfire");
		put(8'h98);
		put(8'hD8);
		fire(8'hD8, 20);
		chk(n, 0, "rehold");
		repeat (H) @(posedge clk_sys);
		put(8'hDC);
		fire(8'hDC, 30);
		chk(mx, C, "clamp");
		chk(n, 1, "reflact");
		chk(tog >= 4, 1, "blink");
		put(8'hD8);
		fire(8'hD8, 30);
		chk(mx, 31, "unclamp");
		apb(1'h0, 12'h004, 32'h0);
		chk(rd, 32'h0000_03AC, "status");
		apb(1'h0, 12'h0FC, 32'h0);
		chk(sl, 1, "unmapped");
		apb(1'h1, 12'h004, $random(seed));
		apb(1'h1, 12'h000, 32'h1);
		m_tick = 0;
		put(8'hD8);
		apb(1'h0, 12'h000, 32'h0);
		chk(rd, 32'h1, "ctrl");
		apb(1'h1, 12'h000, 32'h0);
		m_oem = 0;
		put(8'h58);
		put(8'hD8);
		apb(1'h0, 12'h004, 32'h0);
		chk(rd, 32'h0000_0409, "latched");
		put(8'hD9);
		put(8'hF8);
		put(8'hD9);
		fire(8'hD8, 20);
		chk(n, 0, "hot");
		nrst <= 1'h0;
		repeat (5) @(posedge clk_sys);
		nrst <= 1'h1;
		m_temp = 0;
		m_tick = 1;
		m_oem = 1;
		m_lat = 0;
		put(8'hD8);
		test_done;
	end
endmodule
bind lsis_top lsis_chk #(.HOLDOFF_CYC(HOLDOFF_CYC), .CLAMP_CYC(CLAMP_CYC))
	chk (.*);
